// ==== rtl/adccal_pkg.sv ====
// Package for the converter calibration and output register bank
package adccal_pkg;

  localparam int ADCCAL_DATA_W = 24;
  localparam int ADCCAL_CHANNELS = 6;
  localparam int ADCCAL_OUTPUTS = 3;
  localparam int ADCCAL_ADDR_W = 4;
  localparam int ADCCAL_CNT_W = 5;
  localparam int ADCCAL_WORK_W = 52;
  localparam int ADCCAL_GAIN_SHIFT = 23;

  // Register indices on the serial access port
  localparam logic [3:0] ADCCAL_IDX_OUT_DIRECT = 4'h0;
  localparam logic [3:0] ADCCAL_IDX_SYS_OFFSET = 4'h1;
  localparam logic [3:0] ADCCAL_IDX_SYS_GAIN = 4'h2;
  localparam logic [3:0] ADCCAL_IDX_SELF_OFFSET = 4'h3;
  localparam logic [3:0] ADCCAL_IDX_SELF_GAIN = 4'h4;
  localparam logic [3:0] ADCCAL_IDX_RESULT0 = 4'h5;

  // Shift lengths
  localparam logic [4:0] ADCCAL_LEN_OUT_DIRECT = 5'h08;
  localparam logic [4:0] ADCCAL_LEN_WORD = 5'h18;

  // Reset values
  localparam logic [7:0] ADCCAL_RST_OUT_DIRECT = 8'h00;
  localparam logic [23:0] ADCCAL_RST_SYS_OFFSET = 24'h000000;
  localparam logic [23:0] ADCCAL_RST_SYS_GAIN = 24'h7FFFFF;
  localparam logic [23:0] ADCCAL_RST_SELF_OFFSET = 24'h000000;
  localparam logic [23:0] ADCCAL_RST_SELF_GAIN = 24'hBF851B;
  localparam logic [23:0] ADCCAL_RST_RESULT = 24'h000000;

  // Output coding limits
  localparam logic [23:0] ADCCAL_TWOS_MIN = 24'h800000;
  localparam logic [23:0] ADCCAL_TWOS_MAX = 24'h7FFFFF;

  // Sequencer mode field codes
  localparam logic [1:0] ADCCAL_SEQ_MODE1 = 2'h0;
  localparam logic [1:0] ADCCAL_SEQ_MODE2 = 2'h1;
  localparam logic [1:0] ADCCAL_SEQ_MODE3 = 2'h2;
  localparam logic [1:0] ADCCAL_SEQ_RESERVED = 2'h3;

  typedef enum logic {
    ADCCAL_ACC_IDLE = 1'b0,
    ADCCAL_ACC_SHIFT = 1'b1
  } adccal_acc_state_t;

  // Serial access port, bit level, from the two-wire bus engine
  typedef struct packed {
    logic start;
    logic write;
    logic [3:0] addr;
    logic bit_valid;
    logic bit_in;
  } adccal_access_t;

  // Control bits held in the control registers outside this bank
  typedef struct packed {
    logic [1:0] seq_mode;
    logic sleep;
    logic standby;
    logic output_mode_control_bit;
    logic readback_select_bit;
    logic skip_self_offset_bit;
    logic skip_self_gain_bit;
    logic skip_system_offset_bit;
    logic skip_system_gain_bit;
    logic unipolar;
    logic format_offset_binary;
  } adccal_ctrl_t;

  typedef struct packed {
    logic self_cal;
    logic sys_offset_cal;
    logic sys_gain_cal;
    logic converting;
  } adccal_status_t;

  // Working values of the calibration engine
  typedef struct packed {
    logic [23:0] sys_offset;
    logic [23:0] sys_gain;
    logic [23:0] self_offset;
    logic [23:0] self_gain;
  } adccal_internal_t;

  // Raw filter output for one channel
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [23:0] raw;
  } adccal_conv_t;

endpackage : adccal_pkg

// ==== rtl/adccal_regs.sv ====
// Calibration, direct output and result register bank with its correction chain
`timescale 1ns/1ps

// Functional notes
// [R1] Modes 1 and 2: each output follows its direct bit at once.
// [R2] Sleep forces all outputs off; direct register still takes writes.
// [R3] Standby with output mode bit zero: writes update outputs immediately.
// [R4] Mode 3 with output mode bit one: direct register writes are discarded.
// [R5] Direct register stays in effect during any calibration.
// [R6] System offset: 24-bit two's complement, resets zero, calibration never overwrites.
// [R7] System gain: unsigned, resets 0x7FFFFF, calibration never overwrites.
// [R8] Self offset and gain kept untouched by self-calibration.
// [R9] Calibration registers shift in and out MSB first over 24 bits.
// [R10] Readback select one returns user value, zero returns internal working value.
// [R11] Chain: self offset, self gain, system offset, system gain; each skippable.
// [R12] System offset follows self corrections and precedes the 1x/2x scale.
// [R13] Self offset precedes the unipolar 2x scale.
// [R14] Gain values multiply by at most 2x.
// [R15] Host writes refused to registers used by a running calibration.
// [R16] Self gain register resets to 0xBF851B.
// [R17] Six read-only 24-bit results, reset zero, writes ignored, MSB first.
// [R18] Unipolar results are offset binary.
// [R19] Bipolar: format bit one offset binary, zero two's complement.
// [R20] Out-of-range results clamp to format minimum or maximum.
// [R21] Mode field: 00 mode 1, 01 mode 2, 10 mode 3, 11 reserved.
// [R22] Blocked calibration register writes are dropped, old value kept.
module adccal_regs
  import adccal_pkg::*;
#(
  parameter int CHANNELS = ADCCAL_CHANNELS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire adccal_access_t acc,
  output logic acc_bit_out,
  output logic acc_busy,
  input wire adccal_ctrl_t ctrl,
  input wire adccal_status_t status,
  input wire adccal_internal_t internal_value,
  input wire logic [ADCCAL_OUTPUTS-1:0] seq_output,
  input wire adccal_conv_t conv,
  output logic [ADCCAL_OUTPUTS-1:0] general_output,
  output logic [CHANNELS-1:0] result_updated
);

  typedef logic signed [ADCCAL_WORK_W-1:0] adccal_work_t;

  typedef struct packed {
    adccal_acc_state_t acc_state;
    logic acc_write;
    logic [3:0] acc_addr;
    logic [4:0] acc_cnt;
    logic [23:0] shift;
    logic [7:0] output_direct_control;
    logic [23:0] system_offset_value;
    logic [23:0] system_gain_value;
    logic [23:0] self_offset_value;
    logic [23:0] self_gain_value;
    logic [CHANNELS-1:0][23:0] channel_result;
    logic [CHANNELS-1:0] updated;
    logic [ADCCAL_OUTPUTS-1:0] outputs;
  } adccal_state_t;

  localparam adccal_state_t ST_RESET = '{
    acc_state: ADCCAL_ACC_IDLE,
    acc_write: 1'b0,
    acc_addr: 4'h0,
    acc_cnt: 5'h00,
    shift: 24'h000000,
    output_direct_control: ADCCAL_RST_OUT_DIRECT,
    system_offset_value: ADCCAL_RST_SYS_OFFSET,
    system_gain_value: ADCCAL_RST_SYS_GAIN,
    self_offset_value: ADCCAL_RST_SELF_OFFSET,
    self_gain_value: ADCCAL_RST_SELF_GAIN,
    channel_result: {CHANNELS{ADCCAL_RST_RESULT}},
    updated: '0,
    outputs: '0
  };

  adccal_state_t st_reg;
  adccal_state_t st_next;

  // Shift length of the addressed register
  function automatic logic [4:0] reg_length(input logic [3:0] addr);
    reg_length = (addr == ADCCAL_IDX_OUT_DIRECT) ? ADCCAL_LEN_OUT_DIRECT : ADCCAL_LEN_WORD;
  endfunction : reg_length

  // Result register index, or CHANNELS when the address is no result register
  function automatic int result_index(input logic [3:0] addr);
    int idx;
    idx = int'(addr) - int'(ADCCAL_IDX_RESULT0);
    if (idx < 0 || idx >= CHANNELS) begin
      idx = CHANNELS;
    end
    result_index = idx;
  endfunction : result_index

  function automatic adccal_work_t sext24(input logic [23:0] v);
    sext24 = adccal_work_t'($signed(v));
  endfunction : sext24

  // Gain value is a fraction with 1.0 at 2^23, so at most 2x
  function automatic adccal_work_t apply_gain(input adccal_work_t x, input logic [23:0] g);
    adccal_work_t gw;
    adccal_work_t prod;
    gw = adccal_work_t'({28'h0000000, g});
    prod = x * gw;
    apply_gain = prod >>> ADCCAL_GAIN_SHIFT; // [R14]
  endfunction : apply_gain

  // Correction chain and output coding
  function automatic logic [23:0] correct(input logic [23:0] raw, input adccal_ctrl_t c,
                                          input adccal_state_t s);
    adccal_work_t x;
    adccal_work_t lo;
    adccal_work_t hi;
    logic [23:0] code;
    x = sext24(raw);
    if (!c.skip_self_offset_bit) begin
      x = x - sext24(s.self_offset_value); // [R11] [R13]
    end
    if (!c.skip_self_gain_bit) begin
      x = apply_gain(x, s.self_gain_value); // [R11]
    end
    if (!c.skip_system_offset_bit) begin
      x = x - sext24(s.system_offset_value); // [R11] [R12]
    end
    if (!c.skip_system_gain_bit) begin
      x = apply_gain(x, s.system_gain_value); // [R11]
    end
    if (c.unipolar) begin
      x = x <<< 1; // [R12] [R13]
    end
    lo = sext24(ADCCAL_TWOS_MIN);
    hi = sext24(ADCCAL_TWOS_MAX);
    if (x < lo) begin
      code = ADCCAL_TWOS_MIN; // [R20]
    end else if (x > hi) begin
      code = ADCCAL_TWOS_MAX; // [R20]
    end else begin
      code = x[23:0];
    end
    if (c.unipolar || c.format_offset_binary) begin
      code = {~code[23], code[22:0]}; // [R18] [R19]
    end
    correct = code;
  endfunction : correct

  logic write_blocked;
  logic direct_discard;
  logic [23:0] read_value;
  logic [23:0] shifted;
  logic [23:0] corrected;
  int rd_idx;
  int cv_idx;

  // Write lockout for calibration registers in use
  always_comb begin
    unique case (st_reg.acc_addr)
      ADCCAL_IDX_SYS_OFFSET: write_blocked = status.sys_offset_cal; // [R15]
      ADCCAL_IDX_SYS_GAIN: write_blocked = status.sys_gain_cal; // [R15]
      ADCCAL_IDX_SELF_OFFSET: write_blocked = status.self_cal; // [R15]
      ADCCAL_IDX_SELF_GAIN: write_blocked = status.self_cal; // [R15]
      default: write_blocked = 1'b0;
    endcase
  end

  // Mode 3 with sequencer-owned outputs ignores the direct register
  assign direct_discard = (ctrl.seq_mode == ADCCAL_SEQ_MODE3) && ctrl.output_mode_control_bit; // [R4]

  // Value loaded for a read, aligned at the top of the shifter
  always_comb begin
    rd_idx = result_index(acc.addr);
    read_value = 24'h000000;
    unique case (acc.addr)
      ADCCAL_IDX_OUT_DIRECT: read_value = {st_reg.output_direct_control, 16'h0000};
      ADCCAL_IDX_SYS_OFFSET: read_value = ctrl.readback_select_bit ?
          st_reg.system_offset_value : internal_value.sys_offset; // [R10]
      ADCCAL_IDX_SYS_GAIN: read_value = ctrl.readback_select_bit ?
          st_reg.system_gain_value : internal_value.sys_gain; // [R10]
      ADCCAL_IDX_SELF_OFFSET: read_value = ctrl.readback_select_bit ?
          st_reg.self_offset_value : internal_value.self_offset; // [R10]
      ADCCAL_IDX_SELF_GAIN: read_value = ctrl.readback_select_bit ?
          st_reg.self_gain_value : internal_value.self_gain; // [R10]
      default: begin
        if (rd_idx < CHANNELS) begin
          read_value = st_reg.channel_result[rd_idx]; // [R17]
        end
      end
    endcase
  end

  assign shifted = {st_reg.shift[22:0], acc.bit_in};
  assign corrected = correct(conv.raw, ctrl, st_reg);

  always_comb begin
    st_next = st_reg;
    cv_idx = int'(conv.channel);
    st_next.updated = '0;
    unique case (st_reg.acc_state)
      ADCCAL_ACC_IDLE: begin
        if (acc.start) begin
          st_next.acc_state = ADCCAL_ACC_SHIFT;
          st_next.acc_write = acc.write;
          st_next.acc_addr = acc.addr;
          st_next.acc_cnt = reg_length(acc.addr);
          st_next.shift = acc.write ? 24'h000000 : read_value;
        end
      end
      ADCCAL_ACC_SHIFT: begin
        if (acc.bit_valid) begin
          st_next.shift = shifted; // [R9] [R17]
          st_next.acc_cnt = st_reg.acc_cnt - 5'h01;
          if (st_reg.acc_cnt == 5'h01) begin
            st_next.acc_state = ADCCAL_ACC_IDLE;
            if (st_reg.acc_write && !write_blocked) begin // [R22]
              unique case (st_reg.acc_addr)
                ADCCAL_IDX_OUT_DIRECT: begin
                  if (!direct_discard) begin // [R4]
                    st_next.output_direct_control = shifted[7:0]; // [R2] [R3] [R5]
                  end
                end
                ADCCAL_IDX_SYS_OFFSET: st_next.system_offset_value = shifted; // [R6] [R9]
                ADCCAL_IDX_SYS_GAIN: st_next.system_gain_value = shifted; // [R7] [R9]
                ADCCAL_IDX_SELF_OFFSET: st_next.self_offset_value = shifted; // [R8] [R9]
                ADCCAL_IDX_SELF_GAIN: st_next.self_gain_value = shifted; // [R8] [R9]
                default: begin
                  // Result registers and unmapped indices ignore writes
                end
              endcase
            end
          end
        end
      end
    endcase
    // New conversion results; calibration never writes the user registers
    if (conv.valid && cv_idx < CHANNELS) begin
      st_next.channel_result[cv_idx] = corrected; // [R17] [R20]
      st_next.updated[cv_idx] = 1'b1;
    end
    // Output drive: off in sleep, seq_output in mode 3 with the output mode bit, held in reserved mode,
    // else the next value of the direct register, including a write completing this cycle
    if (ctrl.sleep) begin
      st_next.outputs = '0; // [R2]
    end else if (direct_discard) begin
      st_next.outputs = seq_output; // [R4]
    end else if (ctrl.seq_mode == ADCCAL_SEQ_RESERVED) begin
      st_next.outputs = st_reg.outputs; // [R21]
    end else begin
      st_next.outputs = st_next.output_direct_control[ADCCAL_OUTPUTS-1:0]; // [R1] [R3] [R5]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RESET; // [R6] [R7] [R16] [R17]
    end else begin
      st_reg <= st_next;
    end
  end

  assign acc_bit_out = st_reg.shift[23];
  assign acc_busy = (st_reg.acc_state == ADCCAL_ACC_SHIFT);
  assign general_output = st_reg.outputs;
  assign result_updated = st_reg.updated;

endmodule : adccal_regs

// ==== verification/adccal_chk.sv ====
// Port-level checks of the calibration register bank
`timescale 1ns/1ps
module adccal_chk
  import adccal_pkg::*;
#(
  parameter int CHANNELS = ADCCAL_CHANNELS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire adccal_access_t acc,
  input wire logic acc_bit_out,
  input wire logic acc_busy,
  input wire adccal_ctrl_t ctrl,
  input wire adccal_status_t status,
  input wire adccal_internal_t internal_value,
  input wire logic [ADCCAL_OUTPUTS-1:0] seq_output,
  input wire adccal_conv_t conv,
  input wire logic [ADCCAL_OUTPUTS-1:0] general_output,
  input wire logic [CHANNELS-1:0] result_updated
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_start;
    acc.start && !acc_busy;
  endsequence
  sequence s_reserved;
    (ctrl.seq_mode == ADCCAL_SEQ_RESERVED && !ctrl.sleep)[*2];
  endsequence
  AST_BUSY_RISE: assert property (s_start |=> acc_busy)
    else $error("busy did not follow start");
  AST_BUSY_FALL: assert property ($fell(acc_busy) |-> $past(acc.bit_valid))
    else $error("busy dropped without a bit");
  AST_BIT_HOLD: assert property (acc_busy && !acc.bit_valid |=> acc_busy && $stable(acc_bit_out))
    else $error("read bit moved without a bit strobe");
  AST_SLEEP_OFF: assert property (ctrl.sleep |=> general_output == '0)
    else $error("output active in sleep");
  AST_SEQ_DRIVE: assert property (ctrl.seq_mode == ADCCAL_SEQ_MODE3 && ctrl.output_mode_control_bit
    && !ctrl.sleep |=> general_output == $past(seq_output))
    else $error("sequencer drive not on outputs");
  AST_RESERVED_HOLD: assert property (s_reserved |=> $stable(general_output))
    else $error("outputs moved in reserved mode");
  AST_UPD_PULSE: assert property (conv.valid && conv.channel < CHANNELS
    |=> result_updated == (CHANNELS'(1) << $past(conv.channel)))
    else $error("wrong result update pulse");
  AST_UPD_QUIET: assert property (!conv.valid |=> result_updated == '0)
    else $error("result update without conversion");
endmodule : adccal_chk
bind adccal_regs adccal_chk #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .arst_n(arst_n), .acc(acc),
  .acc_bit_out(acc_bit_out), .acc_busy(acc_busy), .ctrl(ctrl), .status(status),
  .internal_value(internal_value), .seq_output(seq_output), .conv(conv),
  .general_output(general_output), .result_updated(result_updated));

// ==== verification/adccal_host.sv ====
// Host model that drives the serial access port of the register bank
`timescale 1ns/1ps
module adccal_host
  import adccal_pkg::*;
(
  input wire logic clk,
  input wire logic acc_busy,
  input wire logic acc_bit_out,
  output adccal_access_t acc
);
  initial acc = '0;
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    int n;
    n = (a == ADCCAL_IDX_OUT_DIRECT) ? 8 : 24;
    q = '0;
    @(negedge clk);
    acc.start = 1'b1;
    acc.write = wr;
    acc.addr = a;
    @(negedge clk);
    acc.start = 1'b0;
    // Strobe stays up across the whole word, one bit taken per edge
    acc.bit_valid = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      q = {q[22:0], acc_bit_out};
      acc.bit_in = d[i];
      @(negedge clk);
    end
    acc.bit_valid = 1'b0;
    // Released data line shows the inverse, never a stale bit
    acc.bit_in = ~acc.bit_in;
    @(negedge clk);
  endtask : xfer
endmodule : adccal_host

// ==== verification/tb.sv ====
// Self-checking bench for the calibration register bank
`timescale 1ns/1ps
module tb import adccal_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  adccal_access_t acc;
  adccal_ctrl_t ctrl = '0;
  adccal_status_t status = '0;
  adccal_internal_t internal_value = '0;
  logic [2:0] seq_output = '0;
  adccal_conv_t conv = '0;
  logic acc_bit_out;
  logic acc_busy;
  logic [2:0] general_output;
  logic [5:0] result_updated;
  int n_errors = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  adccal_regs #(.CHANNELS(6)) u_dut (.clk(clk), .arst_n(arst_n), .acc(acc),
    .acc_bit_out(acc_bit_out), .acc_busy(acc_busy), .ctrl(ctrl), .status(status),
    .internal_value(internal_value), .seq_output(seq_output), .conv(conv),
    .general_output(general_output), .result_updated(result_updated));
  adccal_host u_host (.clk(clk), .acc_busy(acc_busy), .acc_bit_out(acc_bit_out), .acc(acc));
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    logic [23:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    logic [23:0] q;
    u_host.xfer(1'b0, a, 24'h000000, q);
    check(q, e);
  endtask : rd
  task automatic cv(input logic [2:0] ch, input logic [23:0] raw, input logic [23:0] e);
    conv = '{1'b1, ch, raw};
    @(negedge clk);
    conv.valid = 1'b0;
    rd(ADCCAL_IDX_RESULT0 + {1'b0, ch}, e);
  endtask : cv
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    ctrl.readback_select_bit = 1'b1;
    rd(4'h0, 24'h000000);
    rd(4'h1, 24'h000000);
    rd(4'h2, 24'h7FFFFF);
    rd(4'h3, 24'h000000);
    rd(4'h4, 24'hBF851B);
    for (int i = 5; i < 11; i++) rd(4'(i), 24'h000000);
    rd(4'hF, 24'h000000);
    for (int i = 1; i < 5; i++) begin
      wr(4'(i), 24'hA50F30 ^ 24'(i));
      rd(4'(i), 24'hA50F30 ^ 24'(i));
    end
    for (int i = 1; i < 5; i++) begin
      status = {i > 2, i == 1, i == 2, 1'b0};
      wr(4'(i), 24'h123456);
      rd(4'(i), 24'hA50F30 ^ 24'(i));
      wr(4'h0, 24'(i));
      check({21'h0, general_output}, 24'(i) & 24'h7);
    end
    status = '0;
    ctrl.readback_select_bit = 1'b0;
    internal_value = {24'h111111, 24'h222222, 24'h333333, 24'h444444};
    for (int i = 1; i < 5; i++) rd(4'(i), 24'h111111 * 24'(i));
    ctrl.readback_select_bit = 1'b1;
    for (int m = 0; m < 2; m++) begin
      ctrl.seq_mode = 2'(m);
      wr(4'h0, 24'(m + 5));
      check({21'h0, general_output}, 24'(m + 5));
    end
    ctrl.seq_mode = 2'h2;
    ctrl.output_mode_control_bit = 1'b1;
    seq_output = 3'h3;
    wr(4'h0, 24'h000002);
    rd(4'h0, 24'h000006);
    check({21'h0, general_output}, 24'h000003);
    ctrl.output_mode_control_bit = 1'b0;
    ctrl.seq_mode = 2'h3;
    wr(4'h0, 24'h000001);
    check({21'h0, general_output}, 24'h000003);
    ctrl.seq_mode = 2'h0;
    ctrl.sleep = 1'b1;
    wr(4'h0, 24'h000007);
    check({21'h0, general_output}, 24'h000000);
    rd(4'h0, 24'h000007);
    ctrl.sleep = 1'b0;
    ctrl.standby = 1'b1;
    wr(4'h0, 24'h000005);
    check({21'h0, general_output}, 24'h000005);
    ctrl.standby = 1'b0;
    for (int i = 1; i < 5; i++) wr(4'(i), i[0] ? 24'h000010 : 24'h400000);
    {ctrl.skip_self_offset_bit, ctrl.skip_self_gain_bit, ctrl.skip_system_offset_bit,
      ctrl.skip_system_gain_bit} = 4'hF;
    cv(3'h2, 24'h123456, 24'h123456);
    ctrl.format_offset_binary = 1'b1;
    cv(3'h3, 24'h123456, 24'h923456);
    ctrl.unipolar = 1'b1;
    cv(3'h0, 24'h100000, 24'hA00000);
    cv(3'h1, 24'h500000, 24'hFFFFFF);
    cv(3'h4, 24'hA00000, 24'h000000);
    {ctrl.skip_self_offset_bit, ctrl.skip_system_offset_bit} = 2'h0;
    cv(3'h5, 24'h000100, 24'h8001C0);
    ctrl.unipolar = 1'b0;
    ctrl.format_offset_binary = 1'b0;
    {ctrl.skip_self_offset_bit, ctrl.skip_self_gain_bit, ctrl.skip_system_gain_bit} = 3'h0;
    cv(3'h0, 24'h000100, 24'h000034);
    wr(4'h5, 24'hFFFFFF);
    rd(4'h5, 24'h000034);
    // Reset in mid-run must bring back system gain, self gain, result 0, direct register and outputs
    arst_n = 1'b0;
    @(negedge clk);
    check({21'h0, general_output}, 24'h000000);
    arst_n = 1'b1;
    rd(4'h2, 24'h7FFFFF);
    rd(4'h4, 24'hBF851B);
    rd(4'h5, 24'h000000);
    rd(4'h0, 24'h000000);
    summarize();
  end
endmodule : tb
